// *** tb/vhb_host_if_tb.sv ***
// self-checking bench of the host bus interface
`timescale 1ns/100ps
`default_nettype none
`include "vhb_map.svh"
module vhb_host_if_tb;
  localparam int SLOT = 4;
  logic mclk, sys_rst, host_bus16, planar_mode, wide_mode, req_fetch, req_refresh;
  logic [7:0] dml, win_offset, io_wdata, io_rdata, power_up_strap_register, setup_port;
  logic [1:0] mem_size, mem_be, cap_be;
  logic host_mem_req, host_rom_req, host_wr, host_io_req, host_ready, host_xfer16;
  logic bus_at_mode, vga_enable, gnt_fetch, gnt_refresh, mem_we, mem_oe, cap_we, cap_x16;
  logic [16:0] host_addr;
  logic [15:0] host_wdata, host_rdata, io_addr, mem_wdata, cap_wd;
  logic [19:0] mem_addr, cap_addr;
  logic [3:0] ras_sel, cap_ras;
  wire logic [15:0] mem_rdata;
  int n_mismatch, compares;
  // page mode dram model, any column answered in slot
  assign mem_rdata = mem_addr[15:0] ^ 16'h5A3C;
  vhb_host_if #(.SLOT_CYC(SLOT)) i_vhb_host_if (.mclk, .sys_rst,
    .display_memory_data_lines(dml), .host_bus16, .planar_mode, .wide_mode, .mem_size,
    .win_offset, .host_mem_req, .host_rom_req, .host_wr, .host_addr, .host_wdata,
    .host_ready, .host_xfer16, .host_rdata, .host_io_req, .io_addr, .io_wdata, .io_rdata,
    .power_up_strap_register, .bus_at_mode, .setup_port, .vga_enable, .req_fetch,
    .req_refresh, .mem_rdata, .gnt_fetch, .gnt_refresh, .mem_addr, .mem_wdata, .mem_be,
    .mem_we, .mem_oe, .ras_sel);
  vhb_host_model i_vhb_host_model (.mclk, .host_ready, .host_rdata, .io_rdata,
    .host_mem_req, .host_rom_req, .host_wr, .host_addr, .host_wdata, .host_io_req,
    .io_addr, .io_wdata);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // ************
  // slot capture, far side drops its request once served
  // ************
  always @(posedge mclk) begin
    if (mem_oe | mem_we) begin
      cap_addr <= mem_addr;
      cap_be <= mem_be;
      cap_wd <= mem_wdata;
      cap_ras <= ras_sel;
      cap_we <= mem_we;
    end
    if (host_mem_req) cap_x16 <= host_xfer16;
    if (gnt_fetch) req_fetch <= 1'b0;
    if (gnt_refresh) req_refresh <= 1'b0;
    if (!sys_rst) check("slot excl", ((mem_oe | mem_we) & (gnt_fetch | gnt_refresh |
      !host_mem_req)) | (gnt_fetch & gnt_refresh), 0);
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic do_reset(input logic [7:0] v);
    @(posedge mclk);
    #1;
    sys_rst = 1'b1;
    dml = v;
    repeat (20) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    dml = ~v;
    check("strap", power_up_strap_register, 8'(~v));
    check("bus_at", bus_at_mode, !v[2]);
  endtask : do_reset
  task automatic io_tests(input logic at);
    logic rdy;
    logic [7:0] rd, d;
    d = 8'($urandom);
    i_vhb_host_model.io_cycle(1'b1, `VHB_IO_SETUP, d, rdy, rd);
    check("io ready", rdy, 1);
    check("setup", setup_port, at ? d : `VHB_SETUP_RST);
    i_vhb_host_model.io_cycle(1'b0, `VHB_IO_SETUP, 8'h00, rdy, rd);
    check("setup rd", rd, at ? d : `VHB_SETUP_RST);
    i_vhb_host_model.io_cycle(1'b1, `VHB_IO_ENABLE, d, rdy, rd);
    check("enable", vga_enable, d[0]);
    i_vhb_host_model.io_cycle(1'b0, `VHB_IO_ENABLE, 8'h00, rdy, rd);
    check("enable rd", rd, {7'h00, d[0]});
    i_vhb_host_model.io_cycle(1'b0, 16'h0300, 8'h00, rdy, rd);
    check("unmapped", rd, 8'h00);
    i_vhb_host_model.rom_cycle(rdy);
    check("rom ready", rdy, 1);
    $display("test io done");
  endtask : io_tests
  function automatic logic [19:0] exp_addr(input logic [7:0] w, input logic [16:0] a,
    input logic [1:0] sz);
    logic [19:0] m;
    m = (sz == 2'd0) ? `VHB_MASK_256K : (sz == 2'd1) ? `VHB_MASK_512K : `VHB_MASK_1M;
    return ({w, 12'h000} + {3'b000, a}) & m;
  endfunction : exp_addr
  function automatic logic [3:0] exp_ras(input logic [1:0] sz, input logic [19:0] ea);
    return 4'b0001 << (sz == 2'd0 ? 2'd0 : sz == 2'd1 ? {1'b0, ea[18]} : ea[19:18]);
  endfunction : exp_ras
  task automatic mem_test(input logic b16, pl, wd, input logic [1:0] sz, input logic [7:0] w,
    input logic wr, input logic [16:0] a, input logic [15:0] d, input logic [1:0] cont);
    logic w16;
    logic [19:0] ea;
    logic [15:0] md, rd;
    int waits;
    w16 = b16 & wd & !pl;
    ea = exp_addr(w, a, sz);
    md = ea[15:0] ^ 16'h5A3C;
    @(posedge mclk);
    #1;
    host_bus16 = b16;
    planar_mode = pl;
    wide_mode = wd;
    mem_size = sz;
    win_offset = w;
    req_fetch = cont[0];
    req_refresh = cont[1];
    i_vhb_host_model.mem_cycle(wr, a, d, waits, rd);
    if (waits < 0) begin
      n_mismatch++;
      stop_test();
    end
    if (cont == 2'd0) check("waits", waits, SLOT + 2);
    else check("waits long", waits > SLOT + 2, 1);
    check("xfer16", cap_x16, w16);
    check("addr", cap_addr, ea);
    check("ras", cap_ras, exp_ras(sz, ea));
    check("be", cap_be, w16 ? 2'b11 : a[0] ? 2'b10 : 2'b01);
    check("dir", cap_we, wr);
    if (wr) check("wdata", cap_wd, w16 ? d : {2{d[7:0]}});
    else check("rdata", rd, w16 ? md : {8'h00, a[0] ? md[15:8] : md[7:0]});
  endtask : mem_test
  initial begin
    logic b16, pl, wd;
    logic [16:0] a;
    sys_rst = 1'b1;
    dml = 8'h00;
    host_bus16 = 1'b0;
    planar_mode = 1'b0;
    wide_mode = 1'b0;
    mem_size = 2'd0;
    win_offset = 8'h00;
    req_fetch = 1'b0;
    req_refresh = 1'b0;
    n_mismatch = 0;
    compares = 0;
    void'($urandom(32'h4839));
    do_reset(8'($urandom) & 8'hFB);
    io_tests(1'b1);
    mem_test(1'b1, 1'b1, 1'b1, 2'd2, 8'h00, 1'b0, 17'h00001, 16'h0000, 2'd0);
    mem_test(1'b1, 1'b0, 1'b1, 2'd1, 8'h7F, 1'b1, 17'h1FFFE, 16'hBEEF, 2'd0);
    mem_test(1'b0, 1'b0, 1'b1, 2'd0, 8'hFF, 1'b0, 17'h1FFFF, 16'h0000, 2'd1);
    mem_test(1'b1, 1'b0, 1'b1, 2'd3, 8'hC0, 1'b1, 17'h00011, 16'h1234, 2'd3);
    $display("test mem corners done");
    repeat (24) begin
      b16 = 1'($urandom);
      pl = 1'($urandom);
      wd = 1'($urandom);
      a = 17'($urandom);
      if (b16 & wd & !pl) a[0] = 1'b0;
      mem_test(b16, pl, wd, 2'($urandom), 8'($urandom), 1'($urandom), a, 16'($urandom),
        ($urandom & 1) ? 2'd0 : 2'($urandom_range(1, 3)));
    end
    $display("test mem random done");
    do_reset(8'($urandom) | 8'h04);
    io_tests(1'b0);
    mem_test(1'b1, 1'b0, 1'b1, 2'd2, 8'h10, 1'b0, 17'h00400, 16'h0000, 2'd0);
    $display("test channel done");
    stop_test();
  end
endmodule : vhb_host_if_tb
`default_nettype wire

// *** tb/vhb_host_model.sv ***
// host bus master model: memory, rom and io cycles
`timescale 1ns/100ps
`default_nettype none
module vhb_host_model (
  // clock
  input wire logic mclk,
  // answers
  input wire logic host_ready,
  input wire logic [15:0] host_rdata,
  input wire logic [7:0] io_rdata,
  // requests
  output logic host_mem_req,
  output logic host_rom_req,
  output logic host_wr,
  output logic [16:0] host_addr,
  output logic [15:0] host_wdata,
  output logic host_io_req,
  output logic [15:0] io_addr,
  output logic [7:0] io_wdata
);
  initial begin
    host_mem_req = 1'b0;
    host_rom_req = 1'b0;
    host_wr = 1'b0;
    host_addr = 17'h00000;
    host_wdata = 16'h0000;
    host_io_req = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
  end
  // ************
  // memory cycle, held until ready
  // ************
  task automatic mem_cycle(input logic wr, input logic [16:0] a, input logic [15:0] d,
    output int waits, output logic [15:0] rd);
    @(posedge mclk);
    #1;
    host_mem_req = 1'b1;
    host_wr = wr;
    host_addr = a;
    host_wdata = d;
    waits = 0;
    while (waits >= 0) begin
      @(posedge mclk);
      if (host_ready === 1'b1) break;
      waits = (waits > 300) ? -1 : waits + 1;
    end
    rd = host_rdata;
    #1;
    host_mem_req = 1'b0;
    host_addr = ~a;
    host_wdata = ~d;
  endtask : mem_cycle
  // ************
  // io cycle, one byte, no wait
  // ************
  task automatic io_cycle(input logic wr, input logic [15:0] a, input logic [7:0] d,
    output logic rdy, output logic [7:0] rd);
    @(posedge mclk);
    #1;
    host_io_req = 1'b1;
    host_wr = wr;
    io_addr = a;
    io_wdata = d;
    @(posedge mclk);
    rdy = host_ready;
    #1;
    host_io_req = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
    @(posedge mclk);
    rd = io_rdata;
  endtask : io_cycle
  // rom cycle, ready watched each edge
  task automatic rom_cycle(output logic rdy);
    @(posedge mclk);
    #1;
    host_rom_req = 1'b1;
    rdy = 1'b1;
    repeat (3) begin
      @(posedge mclk);
      rdy = rdy & host_ready;
    end
    #1;
    host_rom_req = 1'b0;
  endtask : rom_cycle
endmodule : vhb_host_model
`default_nettype wire

// *** verilog/vhb_host_if.sv ***
// host bus interface top: strap, port decode, sizing, waits, window
`timescale 1ns/100ps
`default_nettype none
`include "vhb_map.svh"
module vhb_host_if
  import vhb_pkg::*;
#(
  parameter int SLOT_CYC = `VHB_SLOT_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // strap sense
  input wire logic [7:0] display_memory_data_lines,
  // mode and setup inputs
  input wire logic host_bus16,
  input wire logic planar_mode,
  input wire logic wide_mode,
  input wire logic [1:0] mem_size,
  input wire logic [7:0] win_offset,
  // host memory and rom cycle
  input wire logic host_mem_req,
  input wire logic host_rom_req,
  input wire logic host_wr,
  input wire logic [16:0] host_addr,
  input wire logic [15:0] host_wdata,
  output logic host_ready,
  output logic host_xfer16,
  output logic [15:0] host_rdata,
  // host io cycle
  input wire logic host_io_req,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // configuration out
  output logic [7:0] power_up_strap_register,
  output logic bus_at_mode,
  output logic [7:0] setup_port,
  output logic vga_enable,
  // display memory
  input wire logic req_fetch,
  input wire logic req_refresh,
  input wire logic [15:0] mem_rdata,
  output logic gnt_fetch,
  output logic gnt_refresh,
  output logic [19:0] mem_addr,
  output logic [15:0] mem_wdata,
  output logic [1:0] mem_be,
  output logic mem_we,
  output logic mem_oe,
  output logic [3:0] ras_sel
);
  // ************
  // helpers
  // ************
  function automatic logic [19:0] size_mask(input logic [1:0] sz);
    case (sz)
      VHB_SZ_256K: size_mask = `VHB_MASK_256K;
      VHB_SZ_512K: size_mask = `VHB_MASK_512K;
      default: size_mask = `VHB_MASK_1M;
    endcase
  endfunction : size_mask
  function automatic logic [3:0] bank_sel(input logic [1:0] sz, input logic [19:0] a);
    case (sz)
      VHB_SZ_256K: bank_sel = 4'h1;
      VHB_SZ_512K: bank_sel = a[18] ? 4'h2 : 4'h1;
      default: bank_sel = 4'(4'h1 << a[19:18]);
    endcase
  endfunction : bank_sel
  // ************
  // strap capture
  // ************
  logic rst_q;
  logic next_rst_q;
  logic [7:0] next_strap;
  always_comb begin
    next_rst_q = sys_rst;
    next_strap = power_up_strap_register;
    if (rst_q && !sys_rst) begin
      next_strap = ~display_memory_data_lines;
    end
  end
  always_ff @(posedge mclk) begin
    rst_q <= next_rst_q;
    if (sys_rst) begin
      power_up_strap_register <= `VHB_STRAP_RST;
    end else begin
      power_up_strap_register <= next_strap;
    end
  end
  assign bus_at_mode = (power_up_strap_register[`VHB_STRAP_BUS_BIT] == VHB_BUS_AT);
  // ************
  // io ports
  // ************
  logic [7:0] next_setup;
  logic next_vga_en;
  logic [7:0] next_io_rdata;
  logic hit_setup;
  logic hit_enable;
  assign hit_setup = bus_at_mode && (io_addr == `VHB_IO_SETUP);
  assign hit_enable = (io_addr == `VHB_IO_ENABLE);
  always_comb begin
    next_setup = setup_port;
    next_vga_en = vga_enable;
    next_io_rdata = io_rdata;
    if (host_io_req && host_wr) begin
      if (hit_setup) begin
        next_setup = io_wdata;
      end
      if (hit_enable) begin
        next_vga_en = io_wdata[0];
      end
    end else if (host_io_req) begin
      if (hit_setup) begin
        next_io_rdata = setup_port;
      end else if (hit_enable) begin
        next_io_rdata = {7'h00, vga_enable};
      end else begin
        next_io_rdata = 8'h00;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      setup_port <= `VHB_SETUP_RST;
      vga_enable <= 1'b0;
      io_rdata <= 8'h00;
    end else begin
      setup_port <= next_setup;
      vga_enable <= next_vga_en;
      io_rdata <= next_io_rdata;
    end
  end
  // ************
  // memory cycle
  // ************
  vhb_state_t state;
  vhb_state_t next_state;
  logic [19:0] next_mem_addr;
  logic [15:0] next_mem_wdata;
  logic [1:0] next_mem_be;
  logic [15:0] next_rdata;
  logic wr_q;
  logic next_wr_q;
  logic wide_ok;
  logic gnt_host;
  logic slot_last;
  logic [19:0] phys;
  assign wide_ok = host_bus16 && !planar_mode && wide_mode;
  assign host_xfer16 = host_mem_req && !host_io_req && wide_ok;
  assign phys = (20'(win_offset) << `VHB_OFS_SHIFT) + 20'(host_addr);
  // ready low only for pending memory cycle
  assign host_ready = !host_mem_req || (state == VHB_DONE);
  assign mem_we = gnt_host && wr_q;
  assign mem_oe = gnt_host && !wr_q;
  assign ras_sel = (gnt_host || gnt_fetch || gnt_refresh) ? bank_sel(mem_size, mem_addr) : 4'h0;
  always_comb begin
    next_state = state;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    next_mem_be = mem_be;
    next_rdata = host_rdata;
    next_wr_q = wr_q;
    case (state)
      VHB_IDLE: begin
        if (host_mem_req) begin
          next_state = VHB_WAIT;
          next_wr_q = host_wr;
          next_mem_addr = phys & size_mask(mem_size);
          if (wide_ok) begin
            next_mem_be = 2'h3;
            next_mem_wdata = host_wdata;
          end else begin
            next_mem_be = host_addr[0] ? 2'h2 : 2'h1;
            next_mem_wdata = {host_wdata[7:0], host_wdata[7:0]};
          end
        end
      end
      VHB_WAIT: begin
        if (gnt_host && slot_last) begin
          next_state = VHB_DONE;
          if (!wr_q) begin
            if (mem_be == 2'h3) begin
              next_rdata = mem_rdata;
            end else if (mem_be == 2'h2) begin
              next_rdata = {8'h00, mem_rdata[15:8]};
            end else begin
              next_rdata = {8'h00, mem_rdata[7:0]};
            end
          end
        end
      end
      VHB_DONE: begin
        if (!host_mem_req) begin
          next_state = VHB_IDLE;
        end
      end
      default: begin
        next_state = VHB_IDLE;
      end
    endcase
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= VHB_IDLE;
      mem_addr <= 20'h00000;
      mem_wdata <= 16'h0000;
      mem_be <= 2'h0;
      host_rdata <= 16'h0000;
      wr_q <= 1'b0;
    end else begin
      state <= next_state;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      mem_be <= next_mem_be;
      host_rdata <= next_rdata;
      wr_q <= next_wr_q;
    end
  end
  vhb_slot_arb #(
    .SLOT_CYC(SLOT_CYC)
  ) u_arb (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .req_refresh(req_refresh),
    .req_fetch(req_fetch),
    .req_host(state == VHB_WAIT),
    .gnt_refresh(gnt_refresh),
    .gnt_fetch(gnt_fetch),
    .gnt_host(gnt_host),
    .slot_last(slot_last)
  );
  // ************
  // checks
  // ************
  property p_strap_load;
    @(posedge mclk) $fell(sys_rst) |=> power_up_strap_register == ~$past(display_memory_data_lines);
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("strap not inverted lines");
  property p_bus_mode;
    @(posedge mclk) disable iff (sys_rst) !$past(sys_rst) && !$past(sys_rst, 2) |->
      $stable(power_up_strap_register) && bus_at_mode == power_up_strap_register[2];
  endproperty
  a_bus_mode: assert property (p_bus_mode) else $error("bus mode not strap bit");
  property p_io_nowait;
    @(posedge mclk) disable iff (sys_rst)
      (host_io_req || host_rom_req) && !host_mem_req |-> host_ready && !host_xfer16;
  endproperty
  a_io_nowait: assert property (p_io_nowait) else $error("io or rom waited or wide");
  property p_planar_narrow;
    @(posedge mclk) disable iff (sys_rst) planar_mode |-> !host_xfer16;
  endproperty
  a_planar_narrow: assert property (p_planar_narrow) else $error("wide planar transfer");
  property p_wide_ok;
    @(posedge mclk) disable iff (sys_rst)
      host_mem_req && !host_io_req && host_bus16 && wide_mode && !planar_mode |-> host_xfer16;
  endproperty
  a_wide_ok: assert property (p_wide_ok) else $error("wide transfer refused");
  property p_wait_hold;
    @(posedge mclk) disable iff (sys_rst)
      host_mem_req && state == VHB_IDLE |-> !host_ready ##1 (!host_ready || !host_mem_req);
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("ready during memory access");
  property p_slot_only;
    @(posedge mclk) disable iff (sys_rst) $rose(state == VHB_DONE) |-> $past(gnt_host && slot_last);
  endproperty
  a_slot_only: assert property (p_slot_only) else $error("transfer outside slot");
  property p_setup_at;
    @(posedge mclk) disable iff (sys_rst)
      host_io_req && host_wr && io_addr == 16'h46E8 |=> setup_port == ($past(bus_at_mode) ?
        $past(io_wdata) : $past(setup_port));
  endproperty
  a_setup_at: assert property (p_setup_at) else $error("setup port decode wrong");
  property p_enable_port;
    @(posedge mclk) disable iff (sys_rst)
      host_io_req && host_wr && io_addr == 16'h0102 |=> vga_enable == $past(io_wdata[0]);
  endproperty
  a_enable_port: assert property (p_enable_port) else $error("enable port not taken");
  property p_window;
    @(posedge mclk) disable iff (sys_rst)
      host_mem_req && state == VHB_IDLE |=> mem_addr ==
        ((($past(20'(win_offset)) << 12) + $past(20'(host_addr))) & size_mask($past(mem_size)));
  endproperty
  a_window: assert property (p_window) else $error("window address wrong");
endmodule : vhb_host_if
`default_nettype wire

// *** verilog/vhb_map.svh ***
// constants for the host bus interface: offsets, strap fields, timing counts
`ifndef VHB_MAP_SVH
`define VHB_MAP_SVH
// ************
// strap
// ************
`define VHB_STRAP_BUS_BIT 2
`define VHB_STRAP_RST 8'h00
// ************
// internal ports
// ************
`define VHB_IO_SETUP 16'h46E8
`define VHB_IO_ENABLE 16'h0102
`define VHB_SETUP_RST 8'h00
// ************
// window and sizes
// ************
`define VHB_OFS_SHIFT 12
`define VHB_WIN_W 17
`define VHB_MASK_256K 20'h3FFFF
`define VHB_MASK_512K 20'h7FFFF
`define VHB_MASK_1M 20'hFFFFF
// ************
// timing
// ************
`define VHB_CLK_NS 4
`define VHB_SLOT_NS 16
`define VHB_SLOT_CYC ((`VHB_SLOT_NS + `VHB_CLK_NS - 1) / `VHB_CLK_NS)
`endif

// *** verilog/vhb_pkg.sv ***
// types of the host bus interface
package vhb_pkg;
  typedef enum logic [1:0] {
    VHB_IDLE = 2'b00,
    VHB_WAIT = 2'b01,
    VHB_DONE = 2'b10
  } vhb_state_t;
  typedef enum logic {
    VHB_BUS_CHAN = 1'b0,
    VHB_BUS_AT = 1'b1
  } vhb_bus_t;
  typedef enum logic [1:0] {
    VHB_SZ_256K = 2'b00,
    VHB_SZ_512K = 2'b01,
    VHB_SZ_1M = 2'b10
  } vhb_size_t;
endpackage : vhb_pkg

// *** verilog/vhb_slot_arb.sv ***
// memory slot arbiter: refresh, display fetch and host
`timescale 1ns/100ps
`default_nettype none
`include "vhb_map.svh"
module vhb_slot_arb
  import vhb_pkg::*;
#(
  parameter int SLOT_CYC = `VHB_SLOT_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // requests
  input wire logic req_refresh,
  input wire logic req_fetch,
  input wire logic req_host,
  // grants and last cycle of slot
  output logic gnt_refresh,
  output logic gnt_fetch,
  output logic gnt_host,
  output logic slot_last
);
  // ************
  // slot state
  // ************
  logic [2:0] gnt;
  logic [2:0] next_gnt;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  generate
    if (SLOT_CYC < 1 || SLOT_CYC > 255) begin : g_chk
      $error("slot length out of range");
    end
  endgenerate
  assign gnt_refresh = gnt[2];
  assign gnt_fetch = gnt[1];
  assign gnt_host = gnt[0];
  assign slot_last = (gnt != 3'h0) && (cnt == 8'(SLOT_CYC - 1));
  always_comb begin
    next_gnt = gnt;
    next_cnt = cnt;
    if (gnt == 3'h0 || slot_last) begin
      next_cnt = 8'h00;
      if (req_refresh) begin
        next_gnt = 3'h4;
      end else if (req_fetch) begin
        next_gnt = 3'h2;
      end else if (req_host && !(slot_last && gnt_host)) begin
        next_gnt = 3'h1;
      end else begin
        next_gnt = 3'h0;
      end
    end else begin
      next_cnt = cnt + 8'h01;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gnt <= 3'h0;
      cnt <= 8'h00;
    end else begin
      gnt <= next_gnt;
      cnt <= next_cnt;
    end
  end
  property p_one_owner;
    @(posedge mclk) disable iff (sys_rst) $onehot0(gnt);
  endproperty
  a_one_owner: assert property (p_one_owner) else $error("two slot owners");
  property p_refresh_first;
    @(posedge mclk) disable iff (sys_rst)
      (gnt == 3'h0 || slot_last) && req_refresh |=> gnt_refresh;
  endproperty
  a_refresh_first: assert property (p_refresh_first) else $error("refresh not first");
endmodule : vhb_slot_arb
`default_nettype wire
